// ==== core/slmi_pkg.sv ====
// slmi_pkg: constants and types of the status indicator
package slmi_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_KHZ       = 10_000;
   localparam int HALF_2HZ_MS   = 250;
   localparam int HALF_2HZ_CYC  = HALF_2HZ_MS * CLK_KHZ;
   localparam int MIN_START_MS  = 3000;
   localparam int MIN_START_CYC = MIN_START_MS * CLK_KHZ;
   localparam int FLICK_MS      = 20;
   localparam int FLICK_CYC     = FLICK_MS * CLK_KHZ;
   localparam int CNT_W         = 25;

   // ---------------------------------------------------------------
   // bus and register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam logic [4:0] OFF_CTRL   = 5'h00;
   localparam logic [4:0] OFF_STATUS = 5'h04;
   localparam logic [4:0] OFF_DATE   = 5'h08;
   localparam logic [4:0] OFF_TIME   = 5'h0C;

   // control register bits
   localparam int CTRL_W        = 19;
   localparam int CB_BOOT_DONE  = 0;
   localparam int CB_START_DONE = 1;
   localparam int CB_ERR_PEND   = 2;
   localparam int CB_HOLD       = 3;
   localparam int CB_DIAG_START = 4;
   localparam int CB_SYS_ERR    = 5;
   localparam int CB_CARD_WR    = 6;
   localparam int CB_HW_LOAD    = 7;
   localparam int CB_BLINK_TEST = 8;
   localparam int CB_CARD_ACC   = 9;
   localparam int CB_MRES_GO    = 10;
   localparam int CB_MRES_FIN   = 11;
   localparam int CB_FACT_RUN   = 12;
   localparam int CB_FACT_OK    = 13;
   localparam int CB_FW_NEW     = 14;
   localparam int CB_FW_RUN     = 15;
   localparam int CB_FW_CARD    = 16;
   localparam int CB_FW_OK      = 17;
   localparam int CB_FW_FAIL    = 18;
   localparam logic [18:0] CTRL_RST = 19'h00000;

   // status register bits
   localparam int ST_MODE_LSB = 0;
   localparam int ST_SW_LSB   = 3;
   localparam int ST_MIN_DONE = 5;
   localparam int ST_DIAG     = 6;
   localparam int ST_SAVE     = 7;
   localparam int ST_LOAD     = 8;
   localparam int ST_FACT     = 9;

   // clock fallback value: year 2009, month 09, day 01, midnight
   localparam logic [31:0] RTC_DEF_DATE = 32'h07D90901;
   localparam logic [31:0] RTC_DEF_TIME = 32'h00000000;

   // ---------------------------------------------------------------
   // mode switch and operating modes
   // ---------------------------------------------------------------
   localparam logic [1:0] SW_STOP = 2'h0;
   localparam logic [1:0] SW_RUN  = 2'h1;
   localparam logic [1:0] SW_MR   = 2'h2;

   localparam int DO_N  = 12;
   localparam int ETH_N = 2;
   localparam int SYNC_W = 13;

   typedef enum logic [2:0] {
      MODE_POWER_APPLIED = 3'h0,
      MODE_STOP          = 3'h1,
      MODE_START         = 3'h3,
      MODE_RUN           = 3'h2,
      MODE_MRES_REQ      = 3'h6,
      MODE_MRES_EXEC     = 3'h7,
      MODE_MRES_DONE     = 3'h5
   } slmi_mode_e;

endpackage : slmi_pkg

// ==== core/slmi_blink.sv ====
// slmi_blink: 1 Hz, 2 Hz and flicker pattern generator
`timescale 1ns/1ps
module slmi_blink
#(
   parameter int HALF_CYC  = slmi_pkg::HALF_2HZ_CYC,
   parameter int FLICK_CYC = slmi_pkg::FLICK_CYC,
   parameter int CW        = slmi_pkg::CNT_W
)
(
   input  wire logic clk,
   input  wire logic reset,
   output logic      blink_1hz,
   output logic      blink_2hz,
   output logic      flicker
);

   logic [CW-1:0] half_cnt;
   logic [CW-1:0] flick_cnt;
   logic [7:0]    lfsr;

   // ---------------------------------------------------------------
   // blink phases
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         half_cnt  <= '0;
         blink_2hz <= 1'b0;
         blink_1hz <= 1'b0;
      end
      else if (half_cnt == CW'(HALF_CYC - 1))
      begin
         half_cnt  <= '0;
         blink_2hz <= ~blink_2hz;
         // 1 Hz toggles every second 2 Hz toggle, phases stay aligned
         if (blink_2hz)
            blink_1hz <= ~blink_1hz;
      end
      else
         half_cnt <= half_cnt + 1'b1;
   end

   // ---------------------------------------------------------------
   // flicker
   // ---------------------------------------------------------------
   // lfsr gives irregular flicker
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         flick_cnt <= '0;
         lfsr      <= 8'h5A;
         flicker   <= 1'b0;
      end
      else if (flick_cnt == CW'(FLICK_CYC - 1))
      begin
         flick_cnt <= '0;
         lfsr      <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         flicker   <= lfsr[0];
      end
      else
         flick_cnt <= flick_cnt + 1'b1;
   end

endmodule : slmi_blink

// ==== core/slmi_top.sv ====
// slmi_top: status bar, port LEDs and operating mode supervision
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module slmi_top
#(
   parameter int HALF_2HZ_CYC  = slmi_pkg::HALF_2HZ_CYC,
   parameter int MIN_START_CYC = slmi_pkg::MIN_START_CYC,
   parameter int FLICK_CYC     = slmi_pkg::FLICK_CYC
)
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [1:0]  mode_switch,
   input  wire logic        backup_failed,
   input  wire logic        power_fail,
   input  wire logic        save_done,
   input  wire logic        card_present,
   input  wire logic [1:0]  eth_link,
   input  wire logic [1:0]  eth_activity,
   input  wire logic [1:0]  eth_speed100,
   input  wire logic        electronics_supply_feed,
   input  wire logic [11:0] do_state,
   output logic             led_red,
   output logic             led_yellow,
   output logic [1:0]       led_green,
   output logic [1:0]       eth_link_led,
   output logic [1:0]       eth_speed_led,
   output logic [11:0]      do_led,
   output logic             supply_led,
   output logic             ram_save_req,
   output logic             project_load_req
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   localparam int CW = slmi_pkg::CNT_W;

   logic [12:0]         sync1;
   logic [12:0]         sync2;
   logic [1:0]          sw;
   logic                bk_fail;
   logic                pwr_fail;
   logic                sv_done;
   logic                card_in;
   logic [1:0]          link;
   logic [1:0]          act;
   logic [1:0]          spd100;
   logic                supply_ok;

   logic [18:0]         ctrl;
   logic [31:0]         rtc_date;
   logic [31:0]         rtc_time;
   logic                diag_flag;
   logic                fact_ok_l;
   logic [1:0]          pu_cnt;
   logic                bus_take;
   logic [31:0]         next_rdata;

   slmi_pkg::slmi_mode_e mode;
   slmi_pkg::slmi_mode_e next_mode;
   logic [CW-1:0]       start_cnt;
   logic                min_done;

   logic                b1;
   logic                b2;
   logic                fl;
   logic                next_red;
   logic                next_yel;
   logic [1:0]          next_grn;

   function automatic logic hit(input logic [4:0] a,
                                input logic [4:0] off);
      hit = (a == off);
   endfunction : hit

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sync1 <= 13'h0000;
         sync2 <= 13'h0000;
      end
      else
      begin
         sync1 <= {mode_switch, backup_failed, power_fail, save_done,
                   card_present, eth_link, eth_activity, eth_speed100,
                   electronics_supply_feed};
         sync2 <= sync1;
      end
   end

   assign sw        = sync2[12:11];
   assign bk_fail   = sync2[10];
   assign pwr_fail  = sync2[9];
   assign sv_done   = sync2[8];
   assign card_in   = sync2[7];
   assign link      = sync2[6:5];
   assign act       = sync2[4:3];
   assign spd100    = sync2[2:1];
   assign supply_ok = sync2[0];

   // ---------------------------------------------------------------
   // pattern generator
   // ---------------------------------------------------------------
   slmi_blink
   #(
      .HALF_CYC  (HALF_2HZ_CYC),
      .FLICK_CYC (FLICK_CYC),
      .CW        (CW)
   )
   u_blink
   (
      .clk       (clk),
      .reset     (reset),
      .blink_1hz (b1),
      .blink_2hz (b2),
      .flicker   (fl)
   );

   // ---------------------------------------------------------------
   // avalon slave, one wait state
   // ---------------------------------------------------------------
   assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;

   always_ff @(posedge clk)
   begin
      if (reset)
         avs_waitrequest <= 1'b1;
      else if ((avs_read | avs_write) & avs_waitrequest)
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   always_comb
   begin
      next_rdata = 32'h00000000;
      if (hit(avs_address, slmi_pkg::OFF_CTRL))
         next_rdata = {13'h0000, ctrl};
      else if (hit(avs_address, slmi_pkg::OFF_STATUS))
      begin
         next_rdata[slmi_pkg::ST_MODE_LSB +: 3] = mode;
         next_rdata[slmi_pkg::ST_SW_LSB +: 2]   = sw;
         next_rdata[slmi_pkg::ST_MIN_DONE]      = min_done;
         next_rdata[slmi_pkg::ST_DIAG]          = diag_flag;
         next_rdata[slmi_pkg::ST_SAVE]          = ram_save_req;
         next_rdata[slmi_pkg::ST_LOAD]          = project_load_req;
         next_rdata[slmi_pkg::ST_FACT]          = fact_ok_l;
      end
      else if (hit(avs_address, slmi_pkg::OFF_DATE))
         next_rdata = rtc_date;
      else if (hit(avs_address, slmi_pkg::OFF_TIME))
         next_rdata = rtc_time;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         avs_readdata <= 32'h00000000;
      else if (avs_read & avs_waitrequest)
         avs_readdata <= next_rdata;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         ctrl <= slmi_pkg::CTRL_RST;
      else if (bus_take & avs_write & hit(avs_address, slmi_pkg::OFF_CTRL))
         ctrl <= avs_writedata[18:0];
   end

   // factory done holds until reset, software cannot clear it
   // latch factory done
   always_ff @(posedge clk)
   begin
      if (reset)
         fact_ok_l <= 1'b0;
      else if (ctrl[slmi_pkg::CB_FACT_OK])
         fact_ok_l <= 1'b1;
   end

   // ---------------------------------------------------------------
   // clock backup check at power up
   // ---------------------------------------------------------------
   // wait for the synchronisers to fill before sampling the pin
   always_ff @(posedge clk)
   begin
      if (reset)
         pu_cnt <= 2'h0;
      else if (pu_cnt != 2'h3)
         pu_cnt <= pu_cnt + 2'h1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rtc_date <= 32'h00000000;
         rtc_time <= 32'h00000000;
      end
      else if (pu_cnt == 2'h2 && bk_fail)
      begin
         rtc_date <= slmi_pkg::RTC_DEF_DATE;
         rtc_time <= slmi_pkg::RTC_DEF_TIME;
      end
      else if (bus_take & avs_write)
      begin
         if (hit(avs_address, slmi_pkg::OFF_DATE))
            rtc_date <= avs_writedata;
         if (hit(avs_address, slmi_pkg::OFF_TIME))
            rtc_time <= avs_writedata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         diag_flag <= 1'b0;
      else if (pu_cnt == 2'h2 && bk_fail)
         diag_flag <= 1'b1;
      else if (bus_take & avs_write
               & hit(avs_address, slmi_pkg::OFF_STATUS)
               & avs_writedata[slmi_pkg::ST_DIAG])
         diag_flag <= 1'b0;
   end

   // ---------------------------------------------------------------
   // power off save
   // ---------------------------------------------------------------
   // request RAM save
   always_ff @(posedge clk)
   begin
      if (reset)
         ram_save_req <= 1'b0;
      else if (pwr_fail)
         ram_save_req <= 1'b1;
      else if (sv_done)
         ram_save_req <= 1'b0;
   end

   // ---------------------------------------------------------------
   // operating mode
   // ---------------------------------------------------------------
   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         slmi_pkg::MODE_POWER_APPLIED:
            if (ctrl[slmi_pkg::CB_BOOT_DONE])
               next_mode = slmi_pkg::MODE_STOP;
         slmi_pkg::MODE_STOP:
            if (sw == slmi_pkg::SW_RUN)
               next_mode = slmi_pkg::MODE_START;
            else if (sw == slmi_pkg::SW_MR)
               next_mode = slmi_pkg::MODE_MRES_REQ;
         slmi_pkg::MODE_START:
            if (min_done & ctrl[slmi_pkg::CB_START_DONE])
               next_mode = slmi_pkg::MODE_RUN;
         slmi_pkg::MODE_RUN:
            if (sw != slmi_pkg::SW_RUN)
               next_mode = slmi_pkg::MODE_STOP;
         slmi_pkg::MODE_MRES_REQ:
            if (sw != slmi_pkg::SW_MR)
               next_mode = slmi_pkg::MODE_STOP;
            else if (ctrl[slmi_pkg::CB_MRES_GO])
               next_mode = slmi_pkg::MODE_MRES_EXEC;
         slmi_pkg::MODE_MRES_EXEC:
            if (ctrl[slmi_pkg::CB_MRES_FIN])
               next_mode = slmi_pkg::MODE_MRES_DONE;
         slmi_pkg::MODE_MRES_DONE:
            if (sw != slmi_pkg::SW_MR)
               next_mode = slmi_pkg::MODE_STOP;
         default:
            next_mode = slmi_pkg::MODE_POWER_APPLIED;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         mode <= slmi_pkg::MODE_POWER_APPLIED;
      else
         mode <= next_mode;
   end

   always_ff @(posedge clk)
   begin
      if (reset || mode != slmi_pkg::MODE_START)
      begin
         start_cnt <= '0;
         min_done  <= 1'b0;
      end
      else if (start_cnt == CW'(MIN_START_CYC - 1))
         min_done <= 1'b1;
      else
         start_cnt <= start_cnt + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         project_load_req <= 1'b0;
      else
         project_load_req <= (mode == slmi_pkg::MODE_MRES_DONE) & card_in;
   end

   // ---------------------------------------------------------------
   // status bar pattern
   // ---------------------------------------------------------------
   // priority chain, first match wins
   always_comb
   begin
      next_red = 1'b0;
      next_yel = 1'b0;
      next_grn = 2'h0;
      if (ctrl[slmi_pkg::CB_FW_FAIL])
         next_red = b1;
      else if (ctrl[slmi_pkg::CB_FW_OK])
      begin
         next_red = b1;
         next_yel = b1;
      end
      else if (ctrl[slmi_pkg::CB_FW_CARD])
         next_yel = fl;
      else if (ctrl[slmi_pkg::CB_FW_RUN])
         next_yel = b2;
      else if (ctrl[slmi_pkg::CB_FW_NEW])
      begin
         next_red = b1;
         next_yel = ~b1;
      end
      else if (fact_ok_l)
      begin
         next_red = b1;
         next_yel = b1;
      end
      else if (ctrl[slmi_pkg::CB_FACT_RUN])
         next_yel = b2;
      else if (mode == slmi_pkg::MODE_POWER_APPLIED)
         next_yel = b1;
      else if (mode == slmi_pkg::MODE_MRES_REQ)
         next_yel = b1;
      else if (mode == slmi_pkg::MODE_MRES_EXEC)
         next_yel = b2;
      else if (mode == slmi_pkg::MODE_MRES_DONE)
         next_yel = 1'b1;
      else if (ctrl[slmi_pkg::CB_SYS_ERR] | ctrl[slmi_pkg::CB_CARD_WR])
      begin
         next_red = 1'b1;
         next_yel = 1'b1;
      end
      else if (ctrl[slmi_pkg::CB_HW_LOAD])
         next_yel = b2;
      else if (ctrl[slmi_pkg::CB_BLINK_TEST])
         next_grn = {2{b1}};
      else if (mode == slmi_pkg::MODE_START)
      begin
         next_grn = {2{b2}};
         next_red = ctrl[slmi_pkg::CB_DIAG_START] & b1;
      end
      else if (mode == slmi_pkg::MODE_STOP & ctrl[slmi_pkg::CB_HOLD])
      begin
         next_red = 1'b1;
         next_grn = {2{b1}};
      end
      else if (ctrl[slmi_pkg::CB_CARD_ACC])
      begin
         if (mode == slmi_pkg::MODE_RUN)
         begin
            next_red = ctrl[slmi_pkg::CB_ERR_PEND] & b1;
            next_grn = ctrl[slmi_pkg::CB_ERR_PEND] ? {fl, fl} : {1'b1, fl};
         end
         else
            next_yel = fl;
      end
      else if (mode == slmi_pkg::MODE_RUN)
      begin
         next_grn = 2'h3;
         next_red = ctrl[slmi_pkg::CB_ERR_PEND] & b1;
      end
      else
         next_yel = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         led_red    <= 1'b0;
         led_yellow <= 1'b0;
         led_green  <= 2'h0;
      end
      else
      begin
         led_red    <= next_red;
         led_yellow <= next_yel;
         led_green  <= next_grn;
      end
   end

   // ---------------------------------------------------------------
   // port, output and supply LEDs
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         eth_link_led  <= 2'h0;
         eth_speed_led <= 2'h0;
         do_led        <= 12'h000;
         supply_led    <= 1'b0;
      end
      else
      begin
         eth_link_led  <= link & ~(act & {2{fl}});
         eth_speed_led <= link & spd100;
         do_led        <= do_state;
         supply_led    <= supply_ok;
      end
   end

endmodule : slmi_top

// ==== dv/slmi_top_properties.sv ====
// slmi_top_properties: port level checks of the status indicator
`timescale 1ns/1ps
module slmi_chk
#(
   parameter int HALF_2HZ_CYC  = 10,
   parameter int MIN_START_CYC = 50,
   parameter int FLICK_CYC     = 3
)
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        power_fail,
   input wire logic        save_done,
   input wire logic [1:0]  eth_link,
   input wire logic [1:0]  eth_activity,
   input wire logic [1:0]  eth_speed100,
   input wire logic        electronics_supply_feed,
   input wire logic [11:0] do_state,
   input wire logic [1:0]  eth_link_led,
   input wire logic [1:0]  eth_speed_led,
   input wire logic [11:0] do_led,
   input wire logic        supply_led,
   input wire logic        ram_save_req
);
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // pin checks wait until the 2-flop pipes hold post-reset values
   logic [2:0] up;
   always_ff @(posedge clk)
      if (reset)
         up <= 3'h0;
      else if (up != 3'h7)
         up <= up + 3'h1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_answers: assert property
      ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered next cycle");
   a_do_led_follow: assert property (up == 3'h7 |-> do_led == $past(do_state))
      else $error("output LED does not follow channel");
   a_supply_led_follow: assert property
      (up == 3'h7 |-> supply_led == $past(electronics_supply_feed, 3))
      else $error("supply LED does not follow supply");
   a_speed_led_rate: assert property
      (up == 3'h7 |-> eth_speed_led == $past(eth_link & eth_speed100, 3))
      else $error("speed LED wrong");
   a_link_led_idle: assert property
      (up == 3'h7 && $past(eth_activity, 3) == 2'h0
       |-> eth_link_led == $past(eth_link, 3))
      else $error("link LED wrong without traffic");
   a_link_led_dark: assert property
      (up == 3'h7 |-> (eth_link_led & ~$past(eth_link, 3)) == 2'h0)
      else $error("link LED lit without link");
   a_save_request_set: assert property
      (up == 3'h7 && $past(power_fail, 3) |-> ram_save_req)
      else $error("power loss gave no save request");
   a_save_request_clear: assert property
      (up == 3'h7 && $past(save_done, 3) && !$past(power_fail, 3)
       |-> !ram_save_req)
      else $error("save request not cleared");
endmodule : slmi_chk

bind slmi_top slmi_chk #(
   .HALF_2HZ_CYC  (HALF_2HZ_CYC),
   .MIN_START_CYC (MIN_START_CYC),
   .FLICK_CYC     (FLICK_CYC)
) u_chk (.clk, .reset, .avs_read, .avs_write, .avs_waitrequest,
   .power_fail, .save_done, .eth_link, .eth_activity, .eth_speed100,
   .electronics_supply_feed, .do_state, .eth_link_led, .eth_speed_led,
   .do_led, .supply_led, .ram_save_req);

// ==== dv/slmi_panel.sv ====
// slmi_panel: front panel with mode switch and lamp blink meters
`timescale 1ns/1ps
module slmi_panel
(
   input  wire logic       clk,
   input  wire logic [1:0] sw_pos,
   output logic [1:0]      mode_switch,
   input  wire logic [2:0] leds,
   output logic [2:0][7:0] half
);
   logic [2:0][7:0] cnt  = '0;
   logic [2:0]      last = '0;
   initial half = '0;
   initial mode_switch = 2'h0;

   // ---------------------------------------------------------------
   // lamp meter: cycles between toggles, 0 once steady
   // ---------------------------------------------------------------
   always @(posedge clk)
   begin
      mode_switch <= sw_pos;
      last        <= leds;
      for (int i = 0; i < 3; i++)
      begin
         cnt[i] <= cnt[i] + 8'h01;
         if (leds[i] != last[i])
         begin
            half[i] <= cnt[i] + 8'h01;
            cnt[i]  <= 8'h00;
         end
         else if (cnt[i] == 8'h3C)
            half[i] <= 8'h00;
      end
   end
endmodule : slmi_panel

// ==== dv/test_status_led_mode_indicator.sv ====
// test_status_led_mode_indicator: directed bench of the status indicator
`timescale 1ns/1ps
module test_status_led_mode_indicator;
   logic        clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic        avs_waitrequest, led_red, led_yellow, supply_led;
   logic        ram_save_req, project_load_req;
   logic [1:0]  sw_pos = 2'h0, mode_switch, led_green, eth_link_led;
   logic [1:0]  eth_speed_led, eth_link = 2'h0, eth_activity = 2'h0;
   logic [1:0]  eth_speed100 = 2'h0;
   logic        backup_failed = 1'b1, power_fail = 1'b0, save_done = 1'b0;
   logic        card_present = 1'b0, electronics_supply_feed = 1'b0;
   logic [11:0] do_state = 12'h000, do_led;
   logic [2:0][7:0] half;
   logic [43:0] tbl [0:12];
   int          mismatches = 0, total_checks = 0;

   slmi_top #(.HALF_2HZ_CYC(10), .MIN_START_CYC(50), .FLICK_CYC(3)) DUT (
      .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .mode_switch, .backup_failed,
      .power_fail, .save_done, .card_present, .eth_link, .eth_activity,
      .eth_speed100, .electronics_supply_feed, .do_state, .led_red,
      .led_yellow, .led_green, .eth_link_led, .eth_speed_led, .do_led,
      .supply_led, .ram_save_req, .project_load_req);
   slmi_panel PNL (.clk, .sw_pos, .mode_switch, .half,
      .leds({led_red, led_yellow, led_green[0]}));

   initial
   begin
      forever #50 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0);
      chk(n, 2);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic rdchk(input logic [4:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask : rdchk

   // lamp code: 00 dark, FF lit, 01 not looked at, else half period
   task automatic leds(input logic [23:0] e);
      logic [2:0] lv;
      repeat (70) @(posedge clk);
      lv = {led_red, led_yellow, led_green[0]};
      chk(led_green[1], led_green[0]);
      for (int i = 0; i < 3; i++)
         if (e[8*i+:8] != 8'h01)
            chk(half[i] != 8'h00 ? half[i] : {8{lv[i]}}, e[8*i+:8]);
   endtask : leds

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      tbl = '{44'h00003_00_00_FF, 44'h00007_14_00_FF, 44'h00023_FF_FF_01,
              44'h00043_FF_FF_01, 44'h000A3_FF_FF_01, 44'h00083_01_0A_01,
              44'h00103_01_01_14, 44'h04003_14_14_01, 44'h08003_01_0A_01,
              44'h3C003_14_14_01, 44'h7C003_14_00_01, 44'h01003_01_0A_01,
              44'h02003_14_14_01};
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      chk(avs_waitrequest, 1);
      leds(24'h00_14_00);
      rdchk(5'h04, 32'h7, 32'h0);
      rdchk(5'h08, 32'hFFFFFFFF, 32'h07D90901);
      rdchk(5'h04, 32'h40, 32'h40);
      bus(1'b1, 5'h04, 32'h40);
      rdchk(5'h04, 32'h40, 32'h0);
      bus(1'b1, 5'h10, 32'hFFFFFFFF);
      rdchk(5'h10, 32'hFFFFFFFF, 32'h0);
      rdchk(5'h00, 32'hFFFFFFFF, 32'h0);
      $display("power-up and registers done");
      bus(1'b1, 5'h00, 32'h11);
      leds(24'h00_FF_00);
      sw_pos <= 2'h1;
      leds(24'h14_01_0A);
      rdchk(5'h04, 32'h7, 32'h3);
      bus(1'b1, 5'h00, 32'h3);
      repeat (10) @(posedge clk);
      rdchk(5'h04, 32'h7, 32'h2);
      $display("start-up done");
      foreach (tbl[k])
      begin
         bus(1'b1, 5'h00, {12'h000, tbl[k][43:24]});
         leds(tbl[k][23:0]);
      end
      $display("pattern table done");
      reset <= 1'b1;
      backup_failed <= 1'b0;
      sw_pos <= 2'h0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rdchk(5'h04, 32'h240, 32'h0);
      bus(1'b1, 5'h00, 32'h9);
      leds(24'hFF_00_14);
      bus(1'b1, 5'h00, 32'h1);
      sw_pos <= 2'h2;
      leds(24'h00_14_01);
      rdchk(5'h04, 32'h7, 32'h6);
      bus(1'b1, 5'h00, 32'h401);
      leds(24'h00_0A_01);
      card_present <= 1'b1;
      bus(1'b1, 5'h00, 32'hC01);
      leds(24'h00_FF_01);
      chk(project_load_req, 1);
      $display("overall reset done");
      do_state <= 12'hA5C;
      eth_link <= 2'h1;
      eth_speed100 <= 2'h1;
      electronics_supply_feed <= 1'b1;
      power_fail <= 1'b1;
      repeat (6) @(posedge clk);
      chk(do_led, 12'hA5C);
      chk(supply_led, 1);
      chk(eth_link_led, 2'h1);
      chk(eth_speed_led, 2'h1);
      chk(ram_save_req, 1);
      eth_activity <= 2'h3;
      power_fail <= 1'b0;
      save_done <= 1'b1;
      repeat (40) @(posedge clk);
      chk(ram_save_req, 0);
      $display("port lamps done");
      conclude;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude;
   end
endmodule : test_status_led_mode_indicator
